// ### verilog/atg_defs.svh
// Constants for the system-bus master transfer generator.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ATG_DEFS_SVH
`define ATG_DEFS_SVH

// ----------------------------------------------------------------------------
// Transfer type codes
// ----------------------------------------------------------------------------
`define ATG_TRAN_ADDR 2'b00
`define ATG_TRAN_SEQ 2'b11

// ----------------------------------------------------------------------------
// Burst hint codes
// ----------------------------------------------------------------------------
`define ATG_BURST_NONE 2'b00
`define ATG_BURST_4 2'b01
`define ATG_BURST_8 2'b10
`define ATG_BURST_BUF 2'b11

// ----------------------------------------------------------------------------
// Protection, size and addressing
// ----------------------------------------------------------------------------
`define ATG_PROT_EVICT 2'b11
`define ATG_SIZE_WORD 2'b10
`define ATG_WORD_STEP 32'h0000_0004
`define ATG_LINE_MASK 32'hFFFF_FFE0
`define ATG_WORD_MASK 32'hFFFF_FFFC
`define ATG_EVICT_HI_OFS 32'h0000_0010
`define ATG_LINE_WORDS 4'h8
`define ATG_HALF_WORDS 4'h4
`define ATG_ONE_WORD 4'h1
`define ATG_TWO_WORDS 4'h2

// ----------------------------------------------------------------------------
// Eviction selections
// ----------------------------------------------------------------------------
`define ATG_EVICT_LO 2'b00
`define ATG_EVICT_HI 2'b01
`define ATG_EVICT_ALL 2'b10

`endif

// ### verilog/atg_pkg.sv
// Types shared by the transfer generator and its beat sequencer.
// Assumes atg_defs.svh is on the include path.
package atg_pkg;

    // ------------------------------------------------------------------------
    // Request kinds from the core and caches
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ATG_K_FETCH_NC,
        ATG_K_LOAD_NC,
        ATG_K_STORE,
        ATG_K_LINEFILL,
        ATG_K_EVICT,
        ATG_K_SWAP,
        ATG_K_WALK
    } atg_kind_t;

    // ------------------------------------------------------------------------
    // Master sequencing states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ATG_ST_RESET,
        ATG_ST_HANDOVER,
        ATG_ST_IDLE,
        ATG_ST_ATRAN,
        ATG_ST_SEQ,
        ATG_ST_TEST
    } atg_state_t;

    // ------------------------------------------------------------------------
    // Beat sequencer state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] left;
    } atg_beat_t;

    // ------------------------------------------------------------------------
    // Master state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rst_sync1;
        logic rst_sync2;
        atg_state_t state;
        atg_kind_t kind;
        logic fetch;
        logic priv;
        logic swap_wr;
        logic [1:0] btran;
        logic bwrite;
        logic [1:0] bsize;
        logic [1:0] bprot;
        logic blok;
        logic [31:0] bd;
        logic bd_oe;
        logic attr_oe;
        logic tran_oe;
        logic areq;
        logic nonidle_address_strobe;
        logic [1:0] burst;
        logic mwp;
        logic req_ready;
        logic [31:0] rdata;
        logic rdata_valid;
        logic wdata_take;
        logic done;
        logic err;
        logic bwait;
        logic blast;
        logic berror;
        logic resp_oe;
        logic [31:0] sl_data;
    } atg_state_reg_t;

endpackage : atg_pkg

// ### verilog/atg_beat_counter.sv
// Address and beat sequencer for one bus transfer.
// Assumes the master loads it once per transfer and steps it per completed beat.
`timescale 1ns/1ns
`default_nettype none
`include "atg_defs.svh"

module atg_beat_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic load_i,
    input wire logic [31:0] base_i,
    input wire logic [3:0] count_i,
    input wire logic step_i,
    // State
    output logic [31:0] addr_o,
    output logic [3:0] left_o
);
    import atg_pkg::*;

    atg_beat_t r;
    atg_beat_t next_r;

    // Load wins over step so a new transfer never inherits an old address
    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.addr = base_i & `ATG_WORD_MASK;
            next_r.left = count_i;
        end else if (step_i && (r.left != 4'h0)) begin
            next_r.addr = r.addr + `ATG_WORD_STEP;
            next_r.left = r.left - `ATG_ONE_WORD;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign addr_o = r.addr;
    assign left_o = r.left;

endmodule : atg_beat_counter
`default_nettype wire

// ### verilog/atg_master.sv
// System-bus master transfer generator with slave-only test mode.
// Assumes grant, slave responses and test-mode bus inputs share clk_i;
// the bus reset pin is asynchronous and is synchronised here.
//
// Notes on behaviour
// - Bus reset is active low, accepted any time, forces safe bus state.
// - Idle default master drives address-only, lock low, data bus floated.
// - After reset become default master unrequested; handover drives only type.
// - Then idle without requesting the bus until a core request starts a strobed address-only cycle.
// - Uncached reads: protection bit 0 low for fetch, high for data.
// - Uncached single reads and fetches use word-aligned addresses.
// - Uncached multiple load: burst hint 00, more-words signal warns end.
// - Single store: hint 11 buffered, 00 unbuffered, word-aligned.
// - Multiple store: hint 11 buffered, 00 unbuffered, word-aligned.
// - Cached loads and fetches are eight-word ascending linefills, hint 10.
// - Eviction: low half or high half hint 01, whole line hint 10.
// - Eviction write-backs drive protection 11.
// - Swap is single read then single write, lock held across both.
// - Page walk: single read, hint 11, protection 10 fetch, 11 data.
// - Test mode: never master, answers as slave when selected.
// - No nonsequential cycles; address-only then sequential instead.
// - Burst hint set with the strobe and held until next transfer.
// - Strobe marks an address-only cycle followed by a sequential one.
`timescale 1ns/1ns
`default_nettype none
`include "atg_defs.svh"

module atg_master (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic bus_reset_n_i,
    // Core request port
    input wire logic req_valid_i,
    input wire atg_pkg::atg_kind_t req_kind_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [1:0] req_size_i,
    input wire logic [3:0] req_count_i,
    input wire logic req_fetch_i,
    input wire logic req_priv_i,
    input wire logic req_buffered_i,
    input wire logic [1:0] req_evict_sel_i,
    input wire logic [31:0] wdata_i,
    output logic req_ready_o,
    output logic wdata_take_o,
    output logic [31:0] rdata_o,
    output logic rdata_valid_o,
    output logic done_o,
    output logic err_o,
    // Arbitration and slave response
    input wire logic grant_i,
    input wire logic wait_i,
    input wire logic error_i,
    output logic areq_o,
    // Master bus outputs
    output logic [1:0] btran_o,
    output logic tran_oe_o,
    output logic [31:0] ba_o,
    output logic bwrite_o,
    output logic [1:0] bsize_o,
    output logic [1:0] bprot_o,
    output logic blok_o,
    output logic attr_oe_o,
    output logic [31:0] bd_o,
    output logic bd_oe_o,
    input wire logic [31:0] bd_i,
    // Transfer hints
    output logic nonidle_address_strobe_o,
    output logic [1:0] burst_o,
    output logic more_words_pending_o,
    // Slave-only test mode
    input wire logic test_mode_i,
    input wire logic dsel_i,
    input wire logic [1:0] btran_i,
    input wire logic bwrite_i,
    output logic bwait_o,
    output logic blast_o,
    output logic berror_o,
    output logic resp_oe_o
);
    import atg_pkg::*;

    // ------------------------------------------------------------------------
    // State and sequencer wiring
    // ------------------------------------------------------------------------
    atg_state_reg_t r;
    atg_state_reg_t next_r;
    logic cnt_load;
    logic [31:0] cnt_base;
    logic [3:0] cnt_count;
    logic cnt_step;
    logic [31:0] cnt_addr;
    logic [3:0] cnt_left;
    logic beat_done;

    atg_beat_counter u_beats (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(cnt_load),
        .base_i(cnt_base),
        .count_i(cnt_count),
        .step_i(cnt_step),
        .addr_o(cnt_addr),
        .left_o(cnt_left)
    );

    // A beat counts only when granted and the slave is not waiting
    assign beat_done = grant_i && !wait_i;

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        next_r = r;
        cnt_load = 1'b0;
        cnt_base = req_addr_i;
        cnt_count = `ATG_ONE_WORD;
        cnt_step = 1'b0;
        // Pulses default low
        next_r.req_ready = 1'b0;
        next_r.rdata_valid = 1'b0;
        next_r.wdata_take = 1'b0;
        next_r.done = 1'b0;
        next_r.err = 1'b0;
        // Bus reset pin passes two flops before use
        next_r.rst_sync1 = bus_reset_n_i;
        next_r.rst_sync2 = r.rst_sync1;

        unique case (r.state)
            ATG_ST_RESET: begin
                // Release leads to the one-cycle handover
                next_r.state = ATG_ST_HANDOVER;
                next_r.tran_oe = 1'b1;
                next_r.btran = `ATG_TRAN_ADDR;
            end
            ATG_ST_HANDOVER: begin
                // Default master without request: full drive, idle cycle
                next_r.state = ATG_ST_IDLE;
                next_r.attr_oe = 1'b1;
                next_r.blok = 1'b0;
                next_r.bd_oe = 1'b0;
            end
            ATG_ST_IDLE: begin
                next_r.btran = `ATG_TRAN_ADDR;
                next_r.nonidle_address_strobe = 1'b0;
                next_r.blok = 1'b0;
                next_r.bd_oe = 1'b0;
                next_r.mwp = 1'b0;
                if (test_mode_i) begin
                    // Never master in test mode: release every shared line
                    next_r.state = ATG_ST_TEST;
                    next_r.tran_oe = 1'b0;
                    next_r.attr_oe = 1'b0;
                    next_r.areq = 1'b0;
                end else if (req_valid_i) begin
                    next_r.req_ready = 1'b1;
                    next_r.kind = req_kind_i;
                    next_r.fetch = req_fetch_i;
                    next_r.priv = req_priv_i;
                    next_r.swap_wr = 1'b0;
                    next_r.areq = 1'b1;
                    next_r.state = ATG_ST_ATRAN;
                    next_r.nonidle_address_strobe = 1'b1;
                    next_r.bsize = `ATG_SIZE_WORD;
                    next_r.bwrite = 1'b0;
                    next_r.bprot = {req_priv_i, !req_fetch_i};
                    next_r.burst = `ATG_BURST_NONE;
                    cnt_load = 1'b1;
                    unique case (req_kind_i)
                        ATG_K_FETCH_NC: begin
                            next_r.bprot = {req_priv_i, 1'b0};
                        end
                        ATG_K_LOAD_NC: begin
                            cnt_count = req_count_i;
                            next_r.bprot = {req_priv_i, 1'b1};
                            next_r.burst = `ATG_BURST_NONE;
                        end
                        ATG_K_STORE: begin
                            cnt_count = req_count_i;
                            next_r.bwrite = 1'b1;
                            next_r.bprot = {req_priv_i, 1'b1};
                            next_r.burst = req_buffered_i ? `ATG_BURST_BUF : `ATG_BURST_NONE;
                        end
                        ATG_K_LINEFILL: begin
                            cnt_base = req_addr_i & `ATG_LINE_MASK;
                            cnt_count = `ATG_LINE_WORDS;
                            next_r.burst = `ATG_BURST_8;
                        end
                        ATG_K_EVICT: begin
                            next_r.bwrite = 1'b1;
                            next_r.bprot = `ATG_PROT_EVICT;
                            cnt_base = req_addr_i & `ATG_LINE_MASK;
                            cnt_count = `ATG_HALF_WORDS;
                            next_r.burst = `ATG_BURST_4;
                            if (req_evict_sel_i == `ATG_EVICT_HI) begin
                                cnt_base = (req_addr_i & `ATG_LINE_MASK) | `ATG_EVICT_HI_OFS;
                            end else if (req_evict_sel_i == `ATG_EVICT_ALL) begin
                                cnt_count = `ATG_LINE_WORDS;
                                next_r.burst = `ATG_BURST_8;
                            end
                        end
                        ATG_K_SWAP: begin
                            next_r.bsize = req_size_i;
                            next_r.bprot = {req_priv_i, 1'b1};
                            next_r.blok = 1'b1;
                        end
                        ATG_K_WALK: begin
                            next_r.bprot = {1'b1, !req_fetch_i};
                            next_r.burst = `ATG_BURST_BUF;
                        end
                        default: begin
                            next_r.state = ATG_ST_IDLE;
                            next_r.nonidle_address_strobe = 1'b0;
                            next_r.areq = 1'b0;
                            next_r.blok = 1'b0;
                        end
                    endcase
                end else begin
                    next_r.areq = 1'b0;
                end
            end
            ATG_ST_ATRAN: begin
                // Address-only cycle with strobe; sequential follows on grant
                if (grant_i) begin
                    next_r.state = ATG_ST_SEQ;
                    next_r.btran = `ATG_TRAN_SEQ;
                    next_r.nonidle_address_strobe = 1'b0;
                    next_r.bd_oe = r.bwrite;
                    next_r.bd = wdata_i;
                    next_r.mwp = (r.kind == ATG_K_LOAD_NC) && (cnt_left > `ATG_ONE_WORD);
                end
            end
            ATG_ST_SEQ: begin
                if (beat_done && error_i) begin
                    // Abort: drop lock and bus, report the failure
                    next_r.state = ATG_ST_IDLE;
                    next_r.btran = `ATG_TRAN_ADDR;
                    next_r.blok = 1'b0;
                    next_r.bd_oe = 1'b0;
                    next_r.mwp = 1'b0;
                    next_r.areq = 1'b0;
                    next_r.done = 1'b1;
                    next_r.err = 1'b1;
                end else if (beat_done) begin
                    cnt_step = 1'b1;
                    next_r.wdata_take = r.bwrite;
                    next_r.rdata_valid = !r.bwrite;
                    next_r.rdata = bd_i;
                    if (cnt_left == `ATG_ONE_WORD) begin
                        if ((r.kind == ATG_K_SWAP) && !r.swap_wr) begin
                            // Locked write half reuses the read address
                            cnt_load = 1'b1;
                            cnt_base = cnt_addr;
                            next_r.swap_wr = 1'b1;
                            next_r.bwrite = 1'b1;
                            next_r.blok = 1'b1;
                            next_r.state = ATG_ST_ATRAN;
                            next_r.btran = `ATG_TRAN_ADDR;
                            next_r.nonidle_address_strobe = 1'b1;
                            next_r.bd_oe = 1'b0;
                        end else begin
                            next_r.state = ATG_ST_IDLE;
                            next_r.btran = `ATG_TRAN_ADDR;
                            next_r.blok = 1'b0;
                            next_r.bd_oe = 1'b0;
                            next_r.areq = 1'b0;
                            next_r.done = 1'b1;
                        end
                        next_r.mwp = 1'b0;
                    end else begin
                        next_r.bd = wdata_i;
                        next_r.mwp = (r.kind == ATG_K_LOAD_NC) && (cnt_left > `ATG_TWO_WORDS);
                    end
                end else if (!grant_i) begin
                    // Bus lost mid-burst: resume with a fresh address-only cycle
                    next_r.state = ATG_ST_ATRAN;
                    next_r.btran = `ATG_TRAN_ADDR;
                    next_r.nonidle_address_strobe = 1'b1;
                    next_r.bd_oe = 1'b0;
                    next_r.mwp = 1'b0;
                end
                // Slave wait: every attribute holds as it is
            end
            ATG_ST_TEST: begin
                // Slave answer is registered, so it lags the select by a cycle
                next_r.resp_oe = dsel_i && (btran_i == `ATG_TRAN_SEQ);
                next_r.bwait = 1'b0;
                next_r.blast = 1'b0;
                next_r.berror = 1'b0;
                next_r.bd_oe = dsel_i && (btran_i == `ATG_TRAN_SEQ) && !bwrite_i;
                next_r.bd = r.sl_data;
                if (dsel_i && (btran_i == `ATG_TRAN_SEQ) && bwrite_i) begin
                    next_r.sl_data = bd_i;
                end
                if (!test_mode_i) begin
                    next_r.state = ATG_ST_HANDOVER;
                    next_r.resp_oe = 1'b0;
                    next_r.bd_oe = 1'b0;
                    next_r.tran_oe = 1'b1;
                    next_r.btran = `ATG_TRAN_ADDR;
                end
            end
        endcase

        // Bus reset overrides everything: safe idle, shared lines released
        if (!r.rst_sync2) begin
            next_r = '0;
            next_r.rst_sync1 = bus_reset_n_i;
            next_r.rst_sync2 = r.rst_sync1;
            next_r.state = ATG_ST_RESET;
            cnt_load = 1'b0;
            cnt_step = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------------
    assign req_ready_o = r.req_ready;
    assign wdata_take_o = r.wdata_take;
    assign rdata_o = r.rdata;
    assign rdata_valid_o = r.rdata_valid;
    assign done_o = r.done;
    assign err_o = r.err;
    assign areq_o = r.areq;
    assign btran_o = r.btran;
    assign tran_oe_o = r.tran_oe;
    assign ba_o = cnt_addr;
    assign bwrite_o = r.bwrite;
    assign bsize_o = r.bsize;
    assign bprot_o = r.bprot;
    assign blok_o = r.blok;
    assign attr_oe_o = r.attr_oe;
    assign bd_o = r.bd;
    assign bd_oe_o = r.bd_oe;
    assign nonidle_address_strobe_o = r.nonidle_address_strobe;
    assign burst_o = r.burst;
    assign more_words_pending_o = r.mwp;
    assign bwait_o = r.bwait;
    assign blast_o = r.blast;
    assign berror_o = r.berror;
    assign resp_oe_o = r.resp_oe;

endmodule : atg_master
`default_nettype wire

// ### testbench/atg_master_asserts.sv
// Port assertions for the bus master transfer generator.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module atg_master_asserts (
    // Watched ports
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic bus_reset_n_i,
    input wire logic grant_i,
    input wire logic wait_i,
    input wire logic [1:0] btran_o,
    input wire logic tran_oe_o,
    input wire logic [31:0] ba_o,
    input wire logic bwrite_o,
    input wire logic [1:0] bprot_o,
    input wire logic blok_o,
    input wire logic bd_oe_o,
    input wire logic areq_o,
    input wire logic nonidle_address_strobe_o,
    input wire logic [1:0] burst_o,
    input wire logic test_mode_i,
    input wire logic dsel_i,
    input wire logic [1:0] btran_i,
    input wire logic resp_oe_o
);
    // ----------------------------------------
    // Bus master properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_no_ntran: assert property (tran_oe_o |-> btran_o != 2'b10)
        else $error("nonsequential cycle");
    chk_idle_safe: assert property (!areq_o && tran_oe_o |-> btran_o == 2'b00 && !blok_o && !bd_oe_o)
        else $error("idle bus not safe");
    // Pin is synchronised, so allow the sync stages before demanding quiet
    chk_reset_safe: assert property (!bus_reset_n_i [*5] |-> !areq_o && !blok_o && !bd_oe_o && btran_o == 2'b00)
        else $error("bus reset not safe");
    chk_strobe_seq: assert property (nonidle_address_strobe_o && grant_i && btran_o == 2'b00 |=> btran_o == 2'b11)
        else $error("strobe not followed by sequential");
    chk_seq_strobed: assert property ($rose(btran_o[0]) |-> $past(nonidle_address_strobe_o))
        else $error("sequential without strobe");
    chk_burst_hold: assert property (btran_o == 2'b11 |-> $stable(burst_o))
        else $error("burst hint moved");
    chk_wait_hold: assert property (btran_o == 2'b11 && wait_i && grant_i |=> btran_o == 2'b11 && $stable(ba_o))
        else $error("attributes moved in wait");
    chk_beat_step: assert property (btran_o == 2'b11 && grant_i && !wait_i ##1 btran_o == 2'b11 |-> ba_o == $past(ba_o) + 32'h4)
        else $error("beat address not ascending");
    chk_evict_prot: assert property (btran_o == 2'b11 && bwrite_o && burst_o inside {2'b01, 2'b10} |-> bprot_o == 2'b11)
        else $error("eviction protection wrong");
    chk_slave_answer: assert property (test_mode_i && dsel_i && btran_i == 2'b11 |=> resp_oe_o && !areq_o)
        else $error("test slave silent");
endmodule : atg_master_asserts
`default_nettype wire

// ### testbench/atg_bus_model.sv
// Bus partner: always-granting arbiter and one memory slave.
// Assumes the master's bus outputs on the same clock.
`timescale 1ns/1ns
`default_nettype none
module atg_bus_model (
    // Clock and mode
    input wire logic clk_i,
    input wire logic slow_i,
    // Master side
    input wire logic [1:0] btran_i,
    input wire logic [31:0] ba_i,
    output logic grant_o,
    output logic wait_o,
    output logic error_o,
    output logic [31:0] bd_o
);
    logic ws = 1'b0;
    // Sole master keeps the grant, so locking needs no arbitration
    assign grant_o = 1'b1;
    assign error_o = 1'b0;
    // Slow mode answers wait once before every done
    assign wait_o = slow_i && btran_i == 2'b11 && !ws;
    always_ff @(posedge clk_i) begin
        ws <= wait_o;
    end
    // Data valid only on done, else inverted so stale reads show
    assign bd_o = (btran_i == 2'b11 && !wait_o) ? {ba_i[15:0], ~ba_i[15:0]} : {~ba_i[15:0], ba_i[15:0]};
endmodule : atg_bus_model
`default_nettype wire

// ### testbench/atg_master_tb.sv
// Self-checking bench for the bus master transfer generator.
// Assumes package, design and bus model compile first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module atg_master_tb;
    import atg_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    int n_mismatch = 0;
    int n_tests = 0;
    logic clk_i = 0, srst_i = 1, bus_reset_n_i = 0, req_valid_i = 0, req_fetch_i = 0, req_priv_i = 0, slow = 0;
    logic req_buffered_i = 0, test_mode_i = 0, dsel_i = 0, bwrite_i = 0, grant_i, wait_i, error_i;
    logic req_ready_o, wdata_take_o, rdata_valid_o, done_o, err_o, areq_o, tran_oe_o, bwrite_o, blok_o;
    logic attr_oe_o, bd_oe_o, nonidle_address_strobe_o, more_words_pending_o, bwait_o, blast_o, berror_o, resp_oe_o;
    logic [1:0] req_size_i = 2'h2, req_evict_sel_i = 0, btran_i = 0, btran_o, bsize_o, bprot_o, burst_o;
    logic [3:0] req_count_i = 0;
    logic [31:0] req_addr_i = 0, wdata_i = 0, bd_i, mbd, twd = 0, rdata_o, ba_o, bd_o, ra = 0;
    logic [38:0] qb[$];
    atg_kind_t req_kind_i = ATG_K_FETCH_NC;
    assign bd_i = test_mode_i ? twd : mbd;
    atg_master dut_u (.*);
    atg_bus_model bus_u (.clk_i(clk_i), .slow_i(slow), .btran_i(btran_o), .ba_i(ba_o), .grant_o(grant_i),
        .wait_o(wait_i), .error_o(error_i), .bd_o(mbd));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Record each done beat; check read and write data
    always @(posedge clk_i) begin
        if (rdata_valid_o === 1'b1) `CHK(rdata_o, {ra[15:0], ~ra[15:0]})
        if (btran_o == 2'b11 && !wait_i) begin
            if (bwrite_o) `CHK(bd_o, wdata_i)
            else ra = ba_o;
            qb.push_back({more_words_pending_o, blok_o, bwrite_o, bprot_o, burst_o, ba_o});
        end
    end
    task automatic summarize;
        $display("Counts: %0d tests, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // One request; f is {fetch, buffered, evict select}
    task automatic run(input atg_kind_t k, input logic [31:0] a, input logic [3:0] n, input logic [3:0] f);
        int i;
        int w;
        logic [31:0] s;
        logic [6:0] e;
        logic [6:0] m;
        i = 0;
        w = (k == ATG_K_LOAD_NC || k == ATG_K_STORE) ? int'(n) : (k == ATG_K_SWAP) ? 2 : 1;
        s = {a[31:2], 2'b00};
        e = {4'h0, !f[3], 2'b00};
        m = (k == ATG_K_LOAD_NC) ? 7'h77 : (k == ATG_K_SWAP) ? 7'h3C : (k >= ATG_K_EVICT) ? 7'h3F : 7'h37;
        case (k)
            ATG_K_STORE: e = {3'b001, 2'b01, f[2], f[2]};
            ATG_K_LINEFILL: e[1:0] = 2'b10;
            ATG_K_EVICT: e = {3'b001, 2'b11, f[1], !f[1]};
            ATG_K_SWAP: e[5] = 1'b1;
            ATG_K_WALK: e[3:0] = {1'b1, !f[3], 2'b11};
            default: ;
        endcase
        if (k == ATG_K_LINEFILL || k == ATG_K_EVICT) begin
            s = {a[31:5], k == ATG_K_EVICT && f[0], 4'h0};
            w = (k == ATG_K_EVICT && !f[1]) ? 4 : 8;
        end
        {req_kind_i, req_addr_i, req_count_i, wdata_i} = {k, a, n, ~a};
        {req_fetch_i, req_buffered_i, req_evict_sel_i} = f;
        req_valid_i = 1'b1;
        qb.delete();
        do begin
            @(posedge clk_i);
            #2;
            i++;
            if (req_ready_o === 1'b1) req_valid_i = 1'b0;
        end while (done_o !== 1'b1 && i < 300);
        `CHK({err_o, done_o}, 2'b01)
        `CHK(qb.size(), w)
        foreach (qb[j]) begin
            `CHK(qb[j][31:0], s + 32'(4 * j * (k != ATG_K_SWAP)))
            `CHK(qb[j][38:32] & m, (e ^ {k == ATG_K_LOAD_NC && j < w - 1, 2'(k == ATG_K_SWAP && j), 4'h0}) & m)
        end
        $display("Test kind %0d done", k);
    endtask : run
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        #2 srst_i = 0;
        repeat (6) @(negedge clk_i);
        #2 bus_reset_n_i = 1;
        repeat (4) @(posedge clk_i);
        #2 `CHK(areq_o, 1'b0)
        for (int p = 0; p < 2; p++) begin
            slow = p[0];
            run(ATG_K_FETCH_NC, 32'h0000_0108, 4'h1, 4'h8);
            run(ATG_K_LOAD_NC, 32'h0000_010B, 4'h5, 4'h0);
            run(ATG_K_STORE, 32'h0000_0204, 4'h1, 4'h4);
            run(ATG_K_STORE, 32'h0000_0208, 4'h2, 4'h0);
            run(ATG_K_LINEFILL, 32'h0000_0104, 4'h8, 4'h8);
            for (int v = 0; v < 3; v++) run(ATG_K_EVICT, 32'h0000_0300, 4'h8, v[3:0]);
            run(ATG_K_SWAP, 32'h0000_0400, 4'h1, 4'h0);
            run(ATG_K_WALK, 32'h0000_0500, 4'h1, 4'h8);
            run(ATG_K_WALK, 32'h0000_0504, 4'h1, 4'h0);
        end
        test_mode_i = 1;
        repeat (3) @(posedge clk_i);
        #2 {twd, dsel_i, btran_i, bwrite_i} = {32'h1234_ABCD, 1'b1, 2'b11, 1'b1};
        @(posedge clk_i);
        #2 {twd, bwrite_i} = 33'h0;
        `CHK(resp_oe_o, 1'b1)
        @(posedge clk_i);
        #2 {dsel_i, btran_i} = 3'h0;
        `CHK(bd_o, 32'h1234_ABCD)
        $display("Test slave done");
        summarize();
    end
endmodule : atg_master_tb
bind atg_master atg_master_asserts chk_u (.*);
`default_nettype wire
